// ==== hw/swbm_master.sv ====
// Single-wire bus master: takes a command frame, runs the bus, returns a response.
// Assumes synchronous inputs, open-drain data line and host byte streams.
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Response FIFO
module swbm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];  // Storage
  logic [AW:0] wptr;  // Write pointer with wrap bit
  logic [AW:0] rptr;  // Read pointer with wrap bit
  wire full = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
  wire empty = (wptr == rptr);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rptr[AW-1:0]];
  // Pointer update
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wptr <= '0;
      rptr <= '0;
    end else begin
      if (in_valid && !full) wptr <= wptr + 1'b1;
      if (out_ready && !empty) rptr <= rptr + 1'b1;
    end
  end
  // Storage write
  always_ff @(posedge clk) begin
    if (in_valid && !full) mem[wptr[AW-1:0]] <= in_data;
  end
endmodule // swbm_fifo

////////////////////////////////////////////////////////////////////////////////
// Top-level master
module swbm_master import swbm_pkg::*; #(
  parameter int RST_CYC = RESET_LOW_CYC,
  parameter int PRES_CYC = PRESENCE_CYC,
  parameter int SLT_CYC = SLOT_CYC,
  parameter int ONE_CYC = LOW_ONE_CYC,
  parameter int SMP_CYC = SAMPLE_CYC,
  parameter int REC_CYC = RECOVER_CYC,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [7:0] cmd_data,
  output logic rsp_valid,
  input wire logic rsp_ready,
  output logic [7:0] rsp_data,
  input wire logic [NUM_LINES-1:0] dio_in,
  output logic [NUM_LINES-1:0] dio_out,
  output logic [NUM_LINES-1:0] dio_oe
);
  localparam logic [18:0] C_RST = 19'(RST_CYC);
  localparam logic [18:0] C_PRES = 19'(PRES_CYC);
  localparam logic [18:0] C_SLT = 19'(SLT_CYC);
  localparam logic [18:0] C_ONE = 19'(ONE_CYC);
  localparam logic [18:0] C_SMP = 19'(SMP_CYC);
  localparam logic [18:0] C_REC = 19'(REC_CYC);

  // Byte of a flat frame vector
  function automatic logic [7:0] frame_byte(input logic [511:0] v, input int idx);
    frame_byte = v[idx*8 +: 8];
  endfunction

  swbm_state_t st;  // Sequencer state
  swbm_phase_t ph;  // Bit phase
  logic [511:0] cmd_v;  // Command frame
  logic [383:0] rdat;  // Response data bytes
  logic [5:0] idx;  // Byte index
  logic [8:0] bidx;  // Bit index in phase
  logic [1:0] sub;  // Search sub-step
  logic a_bit;  // First search read
  logic [7:0] err;  // Error code
  logic [7:0] warn;  // Warnings
  logic [15:0] s16;  // Long sum
  logic [2:0] opts;  // Latched options
  logic [4:0] sense_q;  // Data line number
  logic [4:0] pu_q;  // Pull-up line number
  logic eng_busy;  // Slot engine running
  logic eng_rst;  // Slot is a reset
  logic eng_bit;  // Slot bit value
  logic [18:0] cnt;  // Slot time counter
  logic smp;  // Sampled line level

  ////////////////////////////////////////////////////////////////////////////
  // Frame fields and checks
  wire [7:0] fn = frame_byte(cmd_v, OFF_FUNC);
  wire [7:0] ntx = frame_byte(cmd_v, OFF_NTX);
  wire [7:0] nrx = frame_byte(cmd_v, OFF_NRX);
  wire fn_ok = (fn == FN_SEARCH) || (fn == FN_READ_ID) || (fn == FN_MATCH_ID)
    || (fn == FN_SKIP_ID) || (fn == FN_ALARM);
  wire fn_srch = (fn == FN_SEARCH) || (fn == FN_ALARM);
  // Receive data after the identifier area where one is returned
  wire [5:0] rx_base = fn_srch ? 6'd16 : (fn == FN_READ_ID) ? 6'd8 : 6'd0;
  wire hdr_bad = (frame_byte(cmd_v, 1) != HDR_B1) || (frame_byte(cmd_v, 2) != HDR_B2)
    || (frame_byte(cmd_v, 3) != HDR_B3) || !fn_ok
    || (frame_byte(cmd_v, OFF_SENSE) >= 8'(NUM_LINES))
    || (frame_byte(cmd_v, OFF_PULLUP) >= 8'(NUM_LINES));
  wire cnt_bad = (ntx > 8'(MAX_TX)) || ({1'b0, nrx} > 9'(MAX_RX) - {3'b0, rx_base});
  wire [7:0] next_err = hdr_bad ? ERR_BAD_FRAME : cnt_bad ? ERR_TOO_MANY : ERR_NONE;

  ////////////////////////////////////////////////////////////////////////////
  // Bit phase bookkeeping
  wire [8:0] nbits = (ph == PH_FUNC) ? 9'd8 : (ph == PH_TX) ? {ntx[5:0], 3'b0}
    : (ph == PH_RX) ? {nrx[5:0], 3'b0} : 9'd64;
  wire last_bit = (bidx == nbits - 9'd1) && (ph != PH_SEARCH || sub == 2'd2);
  wire swbm_phase_t after_id = (ntx != 8'h00) ? PH_TX : (nrx != 8'h00) ? PH_RX : PH_END;
  wire swbm_phase_t after_tx = (nrx != 8'h00) ? PH_RX : PH_END;
  wire swbm_phase_t after_fn = fn_srch ? PH_SEARCH : (fn == FN_READ_ID) ? PH_ROMR
    : (fn == FN_MATCH_ID) ? PH_ROMW : after_id;
  wire swbm_phase_t next_ph = (ph == PH_FUNC) ? after_fn : (ph == PH_TX) ? after_tx
    : (ph == PH_RX) ? PH_END : after_id;
  // identifier path bit, low byte first
  wire id_bit = cmd_v[OFF_ID*8 + bidx[5:0]];
  wire [9:0] tx_pos = 10'(OFF_TX*8) + {1'b0, bidx};
  // Search direction: discrepancy follows the path
  wire both0 = !a_bit && !smp;
  wire dir = (a_bit != smp) ? a_bit : both0 ? id_bit : 1'b1;
  logic dir_q;  // Chosen search direction
  wire out_bit = (ph == PH_FUNC) ? fn[bidx[2:0]] : (ph == PH_ROMW) ? id_bit
    : (ph == PH_TX) ? cmd_v[tx_pos[8:0]] : (ph == PH_SEARCH && sub == 2'd2) ? dir_q : 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Slot engine timing
  logic eng_done_q;  // One-cycle slot completion
  wire eng_go = (st == M_RESET || st == M_BITS) && !eng_busy && !eng_done_q;
  wire [18:0] low_len = eng_rst ? C_RST : eng_bit ? C_ONE : C_SLT;
  wire [18:0] samp_at = eng_rst ? C_RST + C_PRES : C_SMP;
  wire [18:0] end_at = eng_rst ? {C_RST[17:0], 1'b0} : C_SLT + C_REC;
  wire drive_low = eng_busy && (cnt < low_len);
  // sense line is the bus data line
  wire line_in = dio_in[sense_q];

  // Slot engine: drives low, samples, ends
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      eng_busy <= 1'b0;
      eng_rst <= 1'b0;
      eng_bit <= 1'b1;
      cnt <= '0;
      smp <= 1'b1;
      eng_done_q <= 1'b0;
    end else begin
      eng_done_q <= eng_busy && (cnt == end_at);
      if (eng_go) begin
        eng_busy <= 1'b1;
        eng_rst <= (st == M_RESET);
        eng_bit <= out_bit;
        cnt <= '0;
      end else if (eng_busy) begin
        cnt <= cnt + 19'd1;
        if (cnt == samp_at) smp <= line_in;
        if (cnt == end_at) eng_busy <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Response byte selection and sums
  wire [8:0] roff = 9'({idx - 6'd16, 3'b000});
  wire [10:0] s8raw = 11'(HDR_B1) + 11'(HDR_B2) + 11'(HDR_B3) + 11'(s16[7:0]) + 11'(s16[15:8]);
  wire [8:0] s8f = 9'(s8raw[7:0]) + 9'(s8raw[10:8]);
  wire [7:0] s8 = s8f[7:0] + 8'(s8f[8]);
  wire [7:0] rbyte = (idx >= 6'(RSP_DATA)) ? rdat[roff +: 8] : (idx == 6'd0) ? s8
    : (idx == 6'd1) ? HDR_B1 : (idx == 6'd2) ? HDR_B2 : (idx == 6'd3) ? HDR_B3
    : (idx == 6'd4) ? s16[7:0] : (idx == 6'd5) ? s16[15:8]
    : (idx == 6'(RSP_ERR)) ? err : (idx == 6'(RSP_WARN)) ? warn : 8'h00;
  wire push = (st == M_SEND);
  wire push_ready;
  assign cmd_ready = (st == M_RECV);

  // Response buffer toward the host
  swbm_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(push),
    .in_ready(push_ready),
    .in_data(rbyte),
    .out_valid(rsp_valid),
    .out_ready(rsp_ready),
    .out_data(rsp_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Main sequencer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st <= M_RECV;
      ph <= PH_FUNC;
      idx <= '0;
      bidx <= '0;
      sub <= '0;
      a_bit <= 1'b0;
      dir_q <= 1'b1;
      err <= ERR_NONE;
      warn <= 8'h00;
      s16 <= '0;
      opts <= '0;
      sense_q <= '0;
      pu_q <= '0;
    end else begin
      case (st)
        M_RECV: begin
          if (cmd_valid) begin
            idx <= idx + 6'd1;
            if (idx == 6'(FRAME_LEN - 1)) st <= M_CHECK;
          end
        end
        M_CHECK: begin
          err <= next_err;
          warn <= 8'h00;
          s16 <= '0;
          idx <= 6'(RSP_ERR);
          opts <= cmd_v[OFF_OPTIONS*8 +: 3];
          pu_q <= cmd_v[OFF_PULLUP*8 +: 5];
          sense_q <= cmd_v[OFF_SENSE*8 +: 5];
          st <= (next_err != ERR_NONE) ? M_SUM : M_RESET;
        end
        M_RESET: begin
          if (eng_done_q) begin
            ph <= PH_FUNC;
            bidx <= '0;
            sub <= '0;
            if (smp) warn[WARN_NO_DEV] <= 1'b1;
            st <= smp ? M_SUM : M_BITS;
          end
        end
        M_BITS: begin
          if (eng_done_q) begin
            if (ph == PH_SEARCH && sub == 2'd0) a_bit <= smp;
            if (ph == PH_SEARCH && sub == 2'd1) begin
              dir_q <= dir;
              if (a_bit && smp) warn[WARN_NO_DEV] <= 1'b1;
            end
            if (ph == PH_SEARCH && sub != 2'd2) begin
              sub <= sub + 2'd1;
            end else if (last_bit) begin
              sub <= '0;
              bidx <= '0;
              ph <= next_ph;
              if (next_ph == PH_END) st <= M_SUM;
            end else begin
              sub <= '0;
              bidx <= bidx + 9'd1;
            end
          end
        end
        M_SUM: begin
          s16 <= s16 + 16'(rbyte);
          idx <= idx + 6'd1;
          if (idx == 6'(FRAME_LEN - 1)) st <= M_SEND;
        end
        default: begin
          if (push_ready) begin
            idx <= idx + 6'd1;
            if (idx == 6'(FRAME_LEN - 1)) st <= M_RECV;
          end
        end
      endcase
    end
  end

  // Command capture and received bits
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cmd_v <= '0;
      rdat <= '0;
    end else begin
      if (st == M_RECV && cmd_valid) cmd_v[{idx, 3'b000} +: 8] <= cmd_data;
      if (st == M_CHECK) rdat <= '0;
      if (st == M_BITS && eng_done_q) begin
        if (ph == PH_ROMR) rdat[bidx[5:0]] <= smp;
        if (ph == PH_SEARCH && sub == 2'd1) begin
          rdat[bidx[5:0]] <= dir;
          if (both0) rdat[9'd64 + bidx] <= 1'b1;
        end
        if (ph == PH_RX) rdat[9'({rx_base, 3'b000}) + bidx] <= smp;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line drivers
  wire bus_idle = !(st == M_RESET || st == M_BITS);
  wire pu_on = bus_idle ? opts[OPT_PU_IDLE] : !drive_low;
  wire pu_level = pu_on ? opts[OPT_PU_POL] : !opts[OPT_PU_POL];
  logic [NUM_LINES-1:0] next_out;
  logic [NUM_LINES-1:0] next_oe;
  // Per-line drive decode
  always_comb begin
    next_out = '0;
    next_oe = '0;
    if (opts[OPT_PU_EN]) begin
      next_out[pu_q] = pu_level;
      next_oe[pu_q] = 1'b1;
    end
    if (drive_low) begin
      next_out[sense_q] = 1'b0;
      next_oe[sense_q] = 1'b1;
    end
  end
  // Registered pin drive
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dio_out <= '0;
      dio_oe <= '0;
    end else begin
      dio_out <= next_out;
      dio_oe <= next_oe;
    end
  end
endmodule // swbm_master
`default_nettype wire

// ==== hw/swbm_pkg.sv ====
// Package for the single-wire bus master: frame layout, codes, bus timing.
// Assumes a 250 MHz system clock and 64-byte command and response frames.
`default_nettype none
package swbm_pkg;
  // Clock period
  localparam int CLK_PERIOD_NS = 4;
  // Bus timing, in ns
  localparam int T_RESET_LOW_NS = 480000;
  localparam int T_PRESENCE_NS = 70000;
  localparam int T_SLOT_NS = 60000;
  localparam int T_LOW_ONE_NS = 6000;
  localparam int T_SAMPLE_NS = 15000;
  localparam int T_RECOVER_NS = 10000;
  // Derived cycle counts (least times round up)
  localparam int RESET_LOW_CYC = (T_RESET_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PRESENCE_CYC = (T_PRESENCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLOT_CYC = (T_SLOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOW_ONE_CYC = (T_LOW_ONE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SAMPLE_CYC = (T_SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVER_CYC = (T_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Frame layout (byte offsets)
  localparam int FRAME_LEN = 64;
  localparam int OFF_OPTIONS = 6;
  localparam int OFF_SENSE = 8;
  localparam int OFF_PULLUP = 9;
  localparam int OFF_FUNC = 11;
  localparam int OFF_ID = 12;
  localparam int OFF_NTX = 21;
  localparam int OFF_NRX = 23;
  localparam int OFF_TX = 24;
  localparam int RSP_ERR = 6;
  localparam int RSP_WARN = 9;
  localparam int RSP_DATA = 16;
  localparam int MAX_TX = 40;
  localparam int MAX_RX = 48;
  localparam int NUM_LINES = 20;
  // Option bits and warning bit
  localparam int OPT_PU_EN = 0;
  localparam int OPT_PU_POL = 1;
  localparam int OPT_PU_IDLE = 2;
  localparam int WARN_NO_DEV = 0;
  // Fixed header bytes
  localparam logic [7:0] HDR_B1 = 8'hf8;
  localparam logic [7:0] HDR_B2 = 8'h1d;
  localparam logic [7:0] HDR_B3 = 8'h3c;
  // Bus function codes
  localparam logic [7:0] FN_SEARCH = 8'hf0;
  localparam logic [7:0] FN_READ_ID = 8'h33;
  localparam logic [7:0] FN_MATCH_ID = 8'h55;
  localparam logic [7:0] FN_SKIP_ID = 8'hcc;
  localparam logic [7:0] FN_ALARM = 8'hec;
  // Error codes
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_BAD_FRAME = 8'h05;
  localparam logic [7:0] ERR_TOO_MANY = 8'h76;
  // Sequencer states and bit phases
  typedef enum logic [2:0] {M_RECV, M_CHECK, M_RESET, M_BITS, M_SUM, M_SEND} swbm_state_t;
  typedef enum logic [2:0] {PH_FUNC, PH_ROMR, PH_ROMW, PH_SEARCH, PH_TX, PH_RX, PH_END}
    swbm_phase_t;
endpackage
`default_nettype wire

// ==== verification/swbm_master_assertions.sv ====
// Checker: port-level properties of the single-wire bus master.
// Assumes it is bound to swbm_master and given its bus timing counts.
`default_nettype none
module swbm_checker import swbm_pkg::*; #(
  parameter int RST_CYC = 40,
  parameter int SLT_CYC = 20,
  parameter int ONE_CYC = 3
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic [7:0] cmd_data,
  input wire logic rsp_valid,
  input wire logic rsp_ready,
  input wire logic [7:0] rsp_data,
  input wire logic [NUM_LINES-1:0] dio_in,
  input wire logic [NUM_LINES-1:0] dio_out,
  input wire logic [NUM_LINES-1:0] dio_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [5:0] take_n; // Command bytes taken
  logic [5:0] pop_n; // Response bytes popped
  logic [NUM_LINES-1:0] oe_q; // Enables a cycle back
  int hi_n; // Cycles since an enable rose
  wire logic take = cmd_valid && cmd_ready;
  wire logic pop = rsp_valid && rsp_ready;
  wire logic oe_rise = |(dio_oe & ~oe_q);
  wire logic oe_fall = |(oe_q & ~dio_oe);
  ////////////////////////////////////////////////////////////////////////////
  // Byte and pulse counters
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      take_n <= '0;
      pop_n <= '0;
      oe_q <= '0;
      hi_n <= 0;
    end else begin
      take_n <= take_n + 6'(take);
      pop_n <= pop_n + 6'(pop);
      oe_q <= dio_oe;
      hi_n <= oe_rise ? 1 : hi_n + 1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence s_last_take;
    take && take_n == 6'd63;
  endsequence
  sequence s_stall;
    rsp_valid && !rsp_ready;
  endsequence
  AST_RST_QUIET: assert property ($fell(sys_rst) |-> dio_oe == '0 && !rsp_valid)
    else $error("lines driven or response pending after reset");
  AST_RDY_AFTER_RST: assert property ($fell(sys_rst) |-> ##[0:2] cmd_ready)
    else $error("command side not ready after reset");
  AST_IDLE_OE: assert property (cmd_ready && $past(cmd_ready) |-> $stable(dio_oe))
    else $error("line enables moved while idle");
  AST_IDLE_OUT: assert property (cmd_ready && $past(cmd_ready) |-> $stable(dio_out))
    else $error("line levels moved while idle");
  AST_PULSE_LEN: assert property (oe_fall |->
    (hi_n == ONE_CYC || hi_n == SLT_CYC || hi_n == RST_CYC))
    else $error("bus low pulse of wrong length");
  AST_FIFO_HOLD: assert property (s_stall |=> rsp_valid && $stable(rsp_data))
    else $error("response byte dropped or changed while stalled");
  AST_FRAME_END: assert property (s_last_take |=> !cmd_ready [*8])
    else $error("command side ready right after a full frame");
  AST_HDR: assert property (pop && pop_n >= 6'd1 && pop_n <= 6'd3 |-> rsp_data ==
    (pop_n == 6'd1 ? HDR_B1 : (pop_n == 6'd2 ? HDR_B2 : HDR_B3)))
    else $error("response header byte wrong");
  AST_RSVD_ZERO: assert property (pop && (pop_n == 6'd7 || pop_n == 6'd8 ||
    (pop_n >= 6'd10 && pop_n <= 6'd15)) |-> rsp_data == 8'h00)
    else $error("reserved response byte not zero");
endmodule // swbm_checker
bind swbm_master swbm_checker #(.RST_CYC(RST_CYC), .SLT_CYC(SLT_CYC), .ONE_CYC(ONE_CYC)) u_chk (
  .clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
  .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_data(rsp_data),
  .dio_in(dio_in), .dio_out(dio_out), .dio_oe(dio_oe));
`default_nettype wire

// ==== verification/swbm_slave_model.sv ====
// Partner: one slave on the data line, answers presence and read slots.
// Assumes a 1 ns time unit and the short bus timing of the bench.
`default_nettype none
module swbm_slave_model (
  input wire logic line,
  input wire logic present,
  input wire logic [127:0] reply,
  output logic pull
);
  timeunit 1ns;
  timeprecision 100ps;
  int slot; // Slots since the last reset pulse
  realtime t0; // Moment the line fell
  // Slot follower: released line floats high through the pull-up
  initial begin
    pull = 1'b0;
    slot = 0;
    forever begin
      @(negedge line);
      if (present && slot >= 8 && slot < 136 && !reply[slot-8]) begin
        pull = 1'b1;
        #40 pull = 1'b0;
      end
      t0 = $realtime;
      @(posedge line);
      if ($realtime - t0 > 100) begin
        slot = 0;
        if (present) begin
          #10 pull = 1'b1;
          #60 pull = 1'b0;
        end
      end else begin
        slot++;
      end
    end
  end
endmodule // swbm_slave_model
`default_nettype wire

// ==== verification/tb_single_wire_bus_master_command.sv ====
// Testbench: command frames in, bus through a slave model, responses out.
// Assumes short bus timing parameters and a pull-up on every line.
`default_nettype none
module tb_single_wire_bus_master_command import swbm_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, sys_rst, cmd_valid, rsp_ready, pull, present, cmd_ready, rsp_valid;
  logic [7:0] cmd_data, rsp_data;
  logic [NUM_LINES-1:0] dio_in, dio_out, dio_oe, oe_acc, out_acc;
  logic [4:0] sense; // Selected data line
  logic [127:0] reply = 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0;
  logic [7:0] cf [64]; // Command frame
  logic [7:0] rs [64]; // Response frame
  int fail_count = 0;
  int cmp_count = 0;
  // Open-drain lines with pull-ups
  assign dio_in = ~(dio_oe & ~dio_out) & ~(NUM_LINES'(pull) << sense);
  // Short bus timing so each slot lasts tens of cycles
  localparam int TB_RST = 40;
  localparam int TB_PRES = 10;
  localparam int TB_SLT = 20;
  localparam int TB_ONE = 3;
  localparam int TB_SMP = 6;
  localparam int TB_REC = 4;
  swbm_master #(.RST_CYC(TB_RST), .PRES_CYC(TB_PRES), .SLT_CYC(TB_SLT), .ONE_CYC(TB_ONE),
    .SMP_CYC(TB_SMP), .REC_CYC(TB_REC)) dut (.clk(clk), .sys_rst(sys_rst),
    .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
    .rsp_ready(rsp_ready), .rsp_data(rsp_data), .dio_in(dio_in), .dio_out(dio_out),
    .dio_oe(dio_oe));
  swbm_slave_model slave (.line(dio_in[sense]), .present(present), .reply(reply),
    .pull(pull));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Per-frame record of lines touched
  always @(negedge clk) begin
    oe_acc = oe_acc | dio_oe;
    out_acc = out_acc | (dio_out & dio_oe);
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic ck(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Bounded wait at falling edges: 0 command ready, 1 response valid
  task automatic wt(input int sel);
    int n;
    n = 0;
    while (((sel == 1) ? rsp_valid : cmd_ready) !== 1'b1 && n < 40000) begin
      @(negedge clk);
      n++;
    end
    if (n == 40000) begin
      fail_count++;
      $display("unexpected at %0t: handshake wait ran out", $time);
      close_out();
    end
  endtask
  task automatic mk(input logic [7:0] fn, opt, sen, pu, ntx, nrx);
    foreach (cf[i]) cf[i] = 8'h00;
    cf[1] = HDR_B1;
    cf[2] = HDR_B2;
    cf[3] = HDR_B3;
    cf[OFF_OPTIONS] = opt;
    cf[OFF_SENSE] = sen;
    cf[OFF_PULLUP] = pu;
    cf[OFF_FUNC] = fn;
    cf[OFF_NTX] = ntx;
    cf[OFF_NRX] = nrx;
    for (int i = 0; i < 8; i++) cf[OFF_ID+i] = reply[8*i+:8];
    for (int i = 0; i < MAX_TX; i++) cf[OFF_TX+i] = 8'hff;
    if (sen < 8'h14) sense = sen[4:0];
  endtask
  // Send a frame, optionally stall, then drain the response
  task automatic run(input int stall);
    oe_acc = '0;
    out_acc = '0;
    cmd_valid = 1'b1;
    for (int i = 0; i < 64; i++) begin
      cmd_data = cf[i];
      wt(0);
      @(negedge clk);
    end
    cmd_valid = 1'b0;
    repeat (stall) @(negedge clk);
    if (stall > 0) begin
      ck(cmd_ready, 0);
      ck(rsp_valid, 1);
    end
    rsp_ready = 1'b1;
    for (int i = 0; i < 64; i++) begin
      wt(1);
      rs[i] = rsp_data;
      @(negedge clk);
    end
    rsp_ready = 1'b0;
    ck(rsp_valid, 0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_bad();
    mk(FN_SKIP_ID, 8'h00, 8'h03, 8'h05, 8'h00, 8'h00);
    cf[2] = 8'h10;
    run(0);
    ck(rs[RSP_ERR], ERR_BAD_FRAME);
    ck(oe_acc, 0);
    mk(8'h12, 8'h00, 8'h03, 8'h05, 8'h00, 8'h00);
    run(0);
    ck(rs[RSP_ERR], ERR_BAD_FRAME);
    mk(FN_SKIP_ID, 8'h00, 8'h14, 8'h05, 8'h00, 8'h00);
    run(0);
    ck(rs[RSP_ERR], ERR_BAD_FRAME);
    mk(FN_SKIP_ID, 8'h00, 8'h03, 8'h05, 8'h29, 8'h00);
    run(0);
    ck(rs[RSP_ERR], ERR_TOO_MANY);
    mk(FN_READ_ID, 8'h00, 8'h03, 8'h05, 8'h00, 8'h29);
    run(0);
    ck(rs[RSP_ERR], ERR_TOO_MANY);
  endtask
  // Every function with no slave answering
  task automatic t_funcs();
    logic [7:0] fns [5];
    fns = '{FN_SEARCH, FN_READ_ID, FN_MATCH_ID, FN_SKIP_ID, FN_ALARM};
    present = 1'b0;
    foreach (fns[k]) begin
      mk(fns[k], 8'h00, 8'h03, 8'h05, 8'h00, 8'h00);
      run(0);
      ck(rs[RSP_ERR], ERR_NONE);
      ck(rs[RSP_WARN], 8'h01);
      ck(oe_acc, 20'h00008);
    end
  endtask
  task automatic t_readid();
    present = 1'b1;
    mk(FN_READ_ID, 8'h03, 8'h03, 8'h05, 8'h00, 8'h00);
    run(0);
    ck(rs[RSP_WARN], 8'h00);
    for (int i = 0; i < 8; i++) ck(rs[RSP_DATA+i], reply[8*i+:8]);
    ck(oe_acc, 20'h00028);
    ck(out_acc[5], 1);
    ck({dio_oe[5], dio_out[5]}, 2'b10);
  endtask
  task automatic t_skip();
    mk(FN_SKIP_ID, 8'h05, 8'h07, 8'h05, 8'h01, 8'h02);
    run(0);
    ck({rs[RSP_DATA+1], rs[RSP_DATA]}, reply[23:8]);
    ck(oe_acc[7], 1);
    ck({dio_oe[5], dio_out[5]}, 2'b10);
    mk(FN_SKIP_ID, 8'h07, 8'h07, 8'h05, 8'h00, 8'h01);
    run(800);
    ck(rs[RSP_DATA], reply[7:0]);
    ck({dio_oe[5], dio_out[5]}, 2'b11);
  endtask
  initial begin
    sys_rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_data = 8'h00;
    rsp_ready = 1'b0;
    present = 1'b0;
    sense = 5'h03;
    oe_acc = '0;
    out_acc = '0;
    repeat (10) @(negedge clk);
    sys_rst = 1'b0;
    repeat (2) @(negedge clk);
    ck({cmd_ready, rsp_valid, dio_oe}, {2'b10, 20'h0});
    t_bad();
    t_funcs();
    t_readid();
    t_skip();
    close_out();
  end
endmodule // tb_single_wire_bus_master_command
`default_nettype wire
